// *** rtl/rcause_pkg.sv ***
/*
  constants shared by the reset-cause flag bank and the watchdog front end:
  register offsets, bit positions, reset values, mode encodings, counts.
  assumes a 32-bit apb slave with one aligned word per register.
*/
package rcause_pkg;

  // printed offsets are not all multiples of four: they are indices
  localparam logic [11:0] IDX_BROWNOUT_CONTROL = 12'h049;
  localparam logic [11:0] IDX_CAUSE_PRIMARY = 12'h4F0;
  localparam logic [11:0] IDX_CAUSE_SECONDARY = 12'h4F1;
  localparam logic [11:0] IDX_WDT_CONTROL = 12'h500;
  localparam logic [11:0] IDX_WDT_STATUS = 12'h501;

  // primary flag positions
  localparam int BIT_STACK_OVER = 7;
  localparam int BIT_STACK_UNDER = 6;
  localparam int BIT_WINDOW_VIOL = 5;
  localparam int BIT_WDT_RESET = 4;
  localparam int BIT_PIN_RESET = 3;
  localparam int BIT_RESET_INSTR = 2;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  // secondary flag positions
  localparam int BIT_REGULATOR = 2;
  localparam int BIT_MEMORY_VIOL = 1;
  localparam int BIT_CONFIG_CORRUPT = 0;
  // brown-out control positions
  localparam int BIT_SOFT_BOR_EN = 7;
  localparam int BIT_BOR_ARMED = 0;
  // watchdog control positions
  localparam int BIT_SOFT_EN = 0;
  localparam int PS_LSB = 1;
  localparam int CS_LSB = 6;
  localparam int WIN_LSB = 9;

  // values after power-on or brown-out, plus the software period code and the top legal prescale
  localparam logic [7:0] PRIMARY_POR_VALUE = 8'h3C;
  localparam logic [2:0] SECONDARY_POR_VALUE = 3'h4;
  localparam logic [4:0] PS_DEFAULT = 5'h0B;
  localparam logic [4:0] CPS_SOFTWARE = 5'h1F;
  localparam logic [4:0] PS_MAX_LEGAL = 5'h12;
  localparam logic [2:0] WIN_FULL = 3'h7;

  typedef enum logic [1:0] {
    WDT_MODE_OFF = 2'b00,
    WDT_MODE_SOFT = 2'b01,
    WDT_MODE_AWAKE = 2'b10,
    WDT_MODE_ALWAYS = 2'b11
  } wdt_mode_e;

  // the 1 ms base tick is 31 or 32 oscillator ticks; prescale 1:32 = 1 ms
  localparam int BASE_SHIFT = 5;
  localparam int WDT_CNT_W = 24;

endpackage

// *** rtl/reset_cause_and_watchdog.sv ***
/*
  reset-cause flag bank with apb register access and windowed watchdog.
  assumes: reset event strobes are one-cycle pulses, synchronous to pclk,
  raised by the reset controller while the core is held; osc ticks are
  one-cycle enables already synchronous to pclk.
*/
// The APB register port was decided locally.
`timescale 1ns/10ps
module reset_cause_and_watchdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic pin_reset_event,
  input wire logic instr_reset_event,
  input wire logic regulator_fault_event,
  input wire logic memory_violation_event,
  input wire logic config_corrupt_event,
  input wire logic stack_over_event,
  input wire logic stack_under_event,
  input wire logic brownout_armed_status,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic config_clock_source,
  input wire logic [4:0] config_period_field,
  input wire logic [2:0] config_window_field,
  input wire logic sleep_mode,
  input wire logic watchdog_clear_instruction,
  input wire logic low_freq_internal_osc,
  input wire logic mid_freq_internal_osc,
  output logic watchdog_reset_req,
  output logic watchdog_wake
);
  import rcause_pkg::*;

  logic [7:0] primary_reg;
  logic [2:0] secondary_reg;
  logic soft_bor_en_reg;
  logic soft_en_reg;
  logic [4:0] prescale_reg;
  logic [2:0] clock_sel_reg;
  logic [2:0] window_reg;
  logic armed_reg;
  logic [WDT_CNT_W-1:0] count_reg;
  logic [WDT_CNT_W-1:0] count_next;
  logic violation_pending_reg;
  logic timeout_pending_reg;

  logic cold;
  logic wr;
  logic rd;
  logic [11:0] idx;
  logic mapped;
  logic wdt_active;
  logic tick;
  logic [4:0] period_sel;
  logic [WDT_CNT_W-1:0] period_limit;
  logic window_open;
  logic timed_out;
  logic valid_clear;
  logic bad_clear;
  logic wdt_ctl_write;
  logic wdt_restart;
  logic [31:0] prdata_next;

  // register index from a word address
  function automatic logic [11:0] word_index(input logic [31:0] a);
    return a[13:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] i);
    return (i == IDX_BROWNOUT_CONTROL) || (i == IDX_CAUSE_PRIMARY) ||
           (i == IDX_CAUSE_SECONDARY) || (i == IDX_WDT_CONTROL) ||
           (i == IDX_WDT_STATUS);
  endfunction

  assign cold = por_event | bor_event;
  assign idx = word_index(paddr);
  assign mapped = is_mapped(idx) && (paddr[31:14] == 18'h0) && (paddr[1:0] == 2'b00);
  assign wr = psel & penable & pwrite & mapped;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wdt_ctl_write = wr & (idx == IDX_WDT_CONTROL);

  // primary cause flags; hardware events win over a same-cycle firmware write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_reg <= PRIMARY_POR_VALUE;
    end else begin
      if (wr && idx == IDX_CAUSE_PRIMARY && pstrb[0]) begin
        primary_reg <= pwdata[7:0];
      end
      if (cold) begin
        primary_reg[BIT_WINDOW_VIOL] <= 1'b1;
        primary_reg[BIT_WDT_RESET] <= 1'b1;
        primary_reg[BIT_PIN_RESET] <= 1'b1;
        primary_reg[BIT_RESET_INSTR] <= 1'b1;
        primary_reg[BIT_STACK_OVER] <= 1'b0;
        primary_reg[BIT_STACK_UNDER] <= 1'b0;
        // each cold cause clears only its own flag; the other one keeps its value
        if (por_event) begin
          primary_reg[BIT_POWER_ON] <= 1'b0;
        end
        if (bor_event) begin
          primary_reg[BIT_BROWNOUT] <= 1'b0;
        end
      end else begin
        if (violation_pending_reg) begin
          primary_reg[BIT_WINDOW_VIOL] <= 1'b0;
        end
        if (timeout_pending_reg) begin
          primary_reg[BIT_WDT_RESET] <= 1'b0;
        end
        if (pin_reset_event) begin
          primary_reg[BIT_PIN_RESET] <= 1'b0;
        end
        if (instr_reset_event) begin
          primary_reg[BIT_RESET_INSTR] <= 1'b0;
        end
        if (stack_over_event) begin
          primary_reg[BIT_STACK_OVER] <= 1'b1;
        end
        if (stack_under_event) begin
          primary_reg[BIT_STACK_UNDER] <= 1'b1;
        end
      end
    end
  end

  // secondary cause flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_reg <= SECONDARY_POR_VALUE;
    end else begin
      if (wr && idx == IDX_CAUSE_SECONDARY && pstrb[0]) begin
        secondary_reg <= pwdata[2:0];
      end
      if (regulator_fault_event) begin
        secondary_reg[BIT_REGULATOR] <= 1'b0;
        secondary_reg[BIT_CONFIG_CORRUPT] <= config_corrupt_event;
      end else if (cold) begin
        secondary_reg[BIT_REGULATOR] <= 1'b1;
        secondary_reg[BIT_MEMORY_VIOL] <= 1'b0;
        secondary_reg[BIT_CONFIG_CORRUPT] <= config_corrupt_event;
      end else begin
        if (memory_violation_event) begin
          secondary_reg[BIT_MEMORY_VIOL] <= 1'b0;
        end
        if (config_corrupt_event) begin
          secondary_reg[BIT_CONFIG_CORRUPT] <= 1'b1;
        end
      end
    end
  end

  // brown-out soft enable is kept across warm resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_bor_en_reg <= 1'b1;
    end else if (cold) begin
      soft_bor_en_reg <= 1'b1;
    end else if (wr && idx == IDX_BROWNOUT_CONTROL && pstrb[0]) begin
      soft_bor_en_reg <= pwdata[BIT_SOFT_BOR_EN];
    end
  end

  // watchdog control; every device reset except a stack overflow or underflow restores the defaults
  assign wdt_restart = watchdog_reset_req | cold | pin_reset_event | instr_reset_event |
                       regulator_fault_event | memory_violation_event | config_corrupt_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_en_reg <= 1'b0;
    end else if (wdt_restart) begin
      soft_en_reg <= 1'b0;
    end else if (wdt_ctl_write && pstrb[0]) begin
      soft_en_reg <= pwdata[BIT_SOFT_EN];
    end
  end

  // prescale stays read-only unless the configured period hands it to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= PS_DEFAULT;
    end else if (wdt_restart) begin
      prescale_reg <= PS_DEFAULT;
    end else if (wdt_ctl_write && pstrb[0] && config_period_field == CPS_SOFTWARE) begin
      prescale_reg <= pwdata[PS_LSB +: 5];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_sel_reg <= 3'h0;
    end else if (wdt_restart) begin
      clock_sel_reg <= 3'h0;
    end else if (wdt_ctl_write) begin
      if (pstrb[0]) begin
        clock_sel_reg[1:0] <= pwdata[CS_LSB +: 2];
      end
      if (pstrb[1]) begin
        clock_sel_reg[2] <= pwdata[CS_LSB + 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_reg <= WIN_FULL;
    end else if (wdt_restart) begin
      window_reg <= WIN_FULL;
    end else if (wdt_ctl_write && pstrb[1]) begin
      window_reg <= pwdata[WIN_LSB +: 3];
    end
  end

  always_comb begin
    unique case (wdt_mode_e'(watchdog_mode_config))
      WDT_MODE_ALWAYS: wdt_active = 1'b1;
      WDT_MODE_AWAKE: wdt_active = ~sleep_mode;
      WDT_MODE_SOFT: wdt_active = soft_en_reg;
      WDT_MODE_OFF: wdt_active = 1'b0;
    endcase
  end

  // time base: config source in modes 1x, runtime select in mode 01
  always_comb begin
    if (watchdog_mode_config[1]) begin
      tick = config_clock_source ? mid_freq_internal_osc : low_freq_internal_osc;
    end else begin
      unique case (clock_sel_reg)
        3'h0: tick = low_freq_internal_osc;
        3'h1: tick = mid_freq_internal_osc;
        default: tick = 1'b0;
      endcase
    end
  end

  // period select; reserved prescale codes give the 1 ms minimum
  always_comb begin
    period_sel = (config_period_field == CPS_SOFTWARE) ? prescale_reg : config_period_field;
    if (period_sel > PS_MAX_LEGAL) begin
      period_sel = 5'h00;
    end
    period_limit = WDT_CNT_W'(1) << (period_sel + 5'(BASE_SHIFT));
  end

  // window: top three bits of the count against the window delay
  always_comb begin
    logic [2:0] delay_eighths;
    logic [2:0] elapsed_eighths;
    delay_eighths = WIN_FULL - window_reg;
    elapsed_eighths = 3'({count_reg, 3'b000} >> (period_sel + 5'(BASE_SHIFT)));
    window_open = (window_reg == WIN_FULL) || (elapsed_eighths >= delay_eighths);
  end

  assign timed_out = wdt_active && tick && (count_reg + 1'b1 >= period_limit);
  // disarmed clear is a violation even inside the window, unless window_reg is WIN_FULL
  assign valid_clear = watchdog_clear_instruction && window_open &&
                       (armed_reg || window_reg == WIN_FULL);
  assign bad_clear = wdt_active && watchdog_clear_instruction && !valid_clear;

  // arming by reading the watchdog control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (watchdog_clear_instruction || watchdog_reset_req) begin
      armed_reg <= 1'b0;
    end else if (rd && mapped && idx == IDX_WDT_CONTROL) begin
      armed_reg <= 1'b1;
    end
  end

  always_comb begin
    count_next = count_reg;
    if (!wdt_active || valid_clear || wdt_ctl_write || timed_out || watchdog_reset_req) begin
      count_next = '0;
    end else if (tick) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // time-out or violation asks for reset; in sleep a time-out wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset_req <= 1'b0;
      watchdog_wake <= 1'b0;
    end else begin
      watchdog_reset_req <= (timed_out && !sleep_mode) || bad_clear;
      watchdog_wake <= timed_out && sleep_mode;
    end
  end

  // a time-out in sleep only wakes the core, so it is no reset cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      violation_pending_reg <= 1'b0;
      timeout_pending_reg <= 1'b0;
    end else begin
      violation_pending_reg <= bad_clear;
      timeout_pending_reg <= timed_out && !sleep_mode;
    end
  end

  // read word; aliases above the decoded range read zero like any unmapped word
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (mapped) begin
      unique case (idx)
        IDX_CAUSE_PRIMARY: begin
          prdata_next[7:0] = primary_reg;
        end
        IDX_CAUSE_SECONDARY: begin
          prdata_next[2:0] = secondary_reg;
        end
        IDX_BROWNOUT_CONTROL: begin
          prdata_next[7:0] = {soft_bor_en_reg, 6'h00, brownout_armed_status};
        end
        IDX_WDT_CONTROL: begin
          prdata_next[11:0] = {window_reg, clock_sel_reg, prescale_reg, soft_en_reg};
        end
        IDX_WDT_STATUS: begin
          prdata_next[WDT_CNT_W+1:0] = {armed_reg, wdt_active, count_reg};
        end
        default: begin
          prdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // loaded in the setup cycle so it stands through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_next;
    end
  end

endmodule // reset_cause_and_watchdog

// *** test/reset_cause_checker.sv ***
/*
  port-level checker for the reset-cause flag bank and watchdog front end.
  assumes the design answers apb with zero wait states and bus rules are kept.
*/
`timescale 1ns/10ps
module reset_cause_checker
  import rcause_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic pin_reset_event,
  input wire logic instr_reset_event,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic sleep_mode,
  input wire logic watchdog_reset_req,
  input wire logic watchdog_wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic access;
  logic mapped;
  assign access = psel && penable;
  assign mapped = paddr inside {32'h124, 32'h13C0, 32'h13C4, 32'h1400, 32'h1404};
  sequence rd_primary;
    access && !pwrite && paddr == 32'h13C0;
  endsequence
  sequence awake_sleep;
    watchdog_mode_config == WDT_MODE_AWAKE && sleep_mode;
  endsequence
  sequence mode_off;
    watchdog_mode_config == WDT_MODE_OFF;
  endsequence
  unmapped_err_a: assert property (access && !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (access && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  pin_flag_a: assert property (pin_reset_event ##2 rd_primary |-> !prdata[BIT_PIN_RESET])
    else $error("pin flag not cleared");
  instr_flag_a: assert property (instr_reset_event ##2 rd_primary |-> !prdata[BIT_RESET_INSTR])
    else $error("instruction flag not cleared");
  req_pulse_a: assert property (watchdog_reset_req |=> !watchdog_reset_req)
    else $error("reset request longer than one cycle");
  off_quiet_a: assert property (mode_off ##1 mode_off |-> !watchdog_reset_req)
    else $error("reset request while watchdog off");
  sleep_quiet_a: assert property (awake_sleep ##1 awake_sleep |-> !watchdog_reset_req && !watchdog_wake)
    else $error("watchdog acted in sleep");
  fw_write_a: assert property (access && pwrite && paddr == 32'h13C0 |=> !watchdog_reset_req [*2])
    else $error("flag write caused reset");
endmodule // reset_cause_checker

bind reset_cause_and_watchdog reset_cause_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .pin_reset_event, .instr_reset_event,
  .watchdog_mode_config, .sleep_mode, .watchdog_reset_req, .watchdog_wake);

// *** test/reset_cause_and_watchdog_test.sv ***
/*
  self-checking bench: apb reads queue expectations, a monitor compares them.
  assumes oscillator ticks every cycle so prescale 0 times out in 32 cycles.
*/
`timescale 1ns/10ps
module reset_cause_and_watchdog_test;
  import rcause_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] ev;
  logic corrupt, sleep, wclr, req, wake;
  logic [3:0] strb;
  logic bor_ready;
  logic [4:0] cfg_period;
  logic [1:0] mode;
  logic [32:0] q[$];
  int n_fail, cmp_count;
  int seed = 32'hB201;
  logic [7:0] ep [8] = '{8'h3D, 8'h3E, 8'h37, 8'h3B, 8'h3F, 8'h3F, 8'hBF, 8'h7F};
  logic [2:0] es [8] = '{3'h4, 3'h4, 3'h7, 3'h7, 3'h3, 3'h5, 3'h7, 3'h7};
  reset_cause_and_watchdog i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_event(ev[0]),
    .bor_event(ev[1]), .pin_reset_event(ev[2]), .instr_reset_event(ev[3]),
    .regulator_fault_event(ev[4]), .memory_violation_event(ev[5]),
    .config_corrupt_event(corrupt), .stack_over_event(ev[6]), .stack_under_event(ev[7]),
    .brownout_armed_status(bor_ready), .watchdog_mode_config(mode), .config_clock_source(1'b0),
    .config_period_field(cfg_period), .config_window_field(3'h0), .sleep_mode(sleep),
    .watchdog_clear_instruction(wclr), .low_freq_internal_osc(1'b1),
    .mid_freq_internal_osc(1'b1), .watchdog_reset_req(req), .watchdog_wake(wake));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // taken at the closing access edge, before any update scheduled there lands
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) check({pslverr, prdata}, q.pop_front());
  end
  // entered just after a rising edge; leaves one idle cycle so drivers never double-assign
  task automatic apb(input logic wr, input logic [31:0] a, d, input logic [32:0] e);
    int n;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    if (!wr) q.push_back(e);
    @(posedge pclk); penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin n_fail++; complete_run(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask
  task automatic wait_req(input int lim, input logic exp);
    logic got;
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin @(negedge pclk); got = (req === 1'b1); end
    check(33'(got), 33'(exp));
    if (exp && !got) complete_run();
    @(posedge pclk);
  endtask
  // a wake pulse must come, and no reset request with it
  task automatic wait_wake(input int lim);
    logic got, seen_req;
    got = 1'b0;
    seen_req = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge pclk);
      got = (wake === 1'b1);
      seen_req = seen_req | (req === 1'b1);
    end
    check(33'({got, seen_req}), 33'(2'b10));
    if (!got) complete_run();
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial begin
    logic [7:0] v;
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ev = 0; corrupt = 0; sleep = 0; wclr = 0; mode = WDT_MODE_OFF;
    strb = 4'hF;
    bor_ready = 1'b1;
    cfg_period = 5'h1F;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(32'h13C0, 33'h3C);
    rd(32'h13C4, 33'h4);
    rd(32'h124, 33'h81);
    rd(32'h1400, 33'hE16);
    rd(32'h0, {1'b1, 32'h0});
    repeat (4) begin
      v = 8'($random(seed));
      bor_ready <= v[0];
      wr(32'h13C0, {24'h0, v});
      rd(32'h13C0, 33'(v));
      // with lane 0 off the write must leave the flags alone
      strb <= 4'hE;
      wr(32'h13C0, {24'h0, ~v});
      strb <= 4'hF;
      rd(32'h13C0, 33'(v));
      rd(32'h124, {25'h0, 1'b1, 6'h00, v[0]});
    end
    // each event from a known base shows which bits it alone may move
    for (int i = 0; i < 8; i++) begin
      wr(32'h13C0, 32'h3F);
      wr(32'h13C4, 32'h7);
      corrupt <= (i == 4);
      ev <= 8'h1 << i;
      @(posedge pclk);
      ev <= 8'h0;
      rd(32'h13C0, 33'(ep[i]));
      rd(32'h13C4, 33'(es[i]));
    end
    corrupt <= 1'b0;
    mode <= WDT_MODE_ALWAYS;
    wr(32'h1400, 32'hE00);
    wr(32'h13C0, 32'h3F);
    wait_req(200, 1'b1);
    rd(32'h13C0, 33'h2F);
    rd(32'h1400, 33'hE16);
    mode <= WDT_MODE_OFF;
    wr(32'h1400, 32'hE00);
    wait_req(100, 1'b0);
    mode <= WDT_MODE_AWAKE;
    sleep <= 1'b1;
    wait_req(100, 1'b0);
    sleep <= 1'b0;
    wait_req(200, 1'b1);
    mode <= WDT_MODE_SOFT;
    wr(32'h1400, 32'hE01);
    wait_req(200, 1'b1);
    mode <= WDT_MODE_ALWAYS;
    wr(32'h1400, 32'h0);
    wr(32'h13C0, 32'h3F);
    // an unarmed clear in the closed window must be refused as a violation
    wclr <= 1'b1;
    @(posedge pclk);
    wclr <= 1'b0;
    wait_req(20, 1'b1);
    rd(32'h13C0, 33'h1F);
    // a time-out in sleep wakes the core with no reset and no flag change
    sleep <= 1'b1;
    wr(32'h1400, 32'hE00);
    wait_wake(200);
    rd(32'h13C0, 33'h1F);
    // a configured period overrides the long software prescale
    sleep <= 1'b0;
    wr(32'h1400, 32'hE16);
    cfg_period <= 5'h00;
    wait_req(200, 1'b1);
    cfg_period <= 5'h1F;
    mode <= WDT_MODE_OFF;
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule // reset_cause_and_watchdog_test
